// ### hw/sqadc_consts.svh
// Constants for the SAR converter channel sequencer
`ifndef SQADC_CONSTS_SVH
`define SQADC_CONSTS_SVH
// ***********************************************
// Clocking and conversion timing
// ***********************************************
`define SQADC_CLK_HZ        10000000
`define SQADC_CONV_MAX_HZ   18000000
`define SQADC_CONV_CYCLES   18
`define SQADC_BIT_CYCLES    12
`define SQADC_RATE_SPS      1000000
// ***********************************************
// Register byte offsets
// ***********************************************
`define SQADC_CTRL_OFS      8'h00
`define SQADC_CHEN_OFS      8'h04
`define SQADC_STAT_OFS      8'h08
`define SQADC_INTR_OFS      8'h0C
`define SQADC_MASK_OFS      8'h10
`define SQADC_LIMLO_OFS     8'h14
`define SQADC_LIMHI_OFS     8'h18
`define SQADC_SAMP_BASE     3'h1
`define SQADC_RES_BASE      3'h2
// ***********************************************
// Field positions and reset values
// ***********************************************
`define SQADC_CTRL_EN       0
`define SQADC_CTRL_FW       1
`define SQADC_CTRL_GO       2
`define SQADC_INT_RANGE     0
`define SQADC_INT_SCAN      1
`define SQADC_INT_CONV      2
`define SQADC_RES_VALID     31
`define SQADC_SAMP_RST      8'h03
`define SQADC_LIMHI_RST     12'hFFF
`define SQADC_DAC_MID       12'h800
`endif

// ### hw/sqadc_pkg.sv
// Types shared by the SAR converter channel sequencer
package sqadc_pkg;
    // ***********************************************
    // Sequencer states, one-hot-ish so bits drive pins
    // ***********************************************
    typedef enum logic [1:0] {
        SQADC_IDLE   = 2'b00,
        SQADC_SAMPLE = 2'b01,
        SQADC_CONV   = 2'b10
    } sqadc_state_e;
    // ***********************************************
    // Bus and analog carriers
    // ***********************************************
    typedef struct packed {
        logic        psel;     // Slave selected
        logic        penable;  // Access phase
        logic        pwrite;   // Write when high
        logic [7:0]  paddr;    // Byte address
        logic [31:0] pwdata;   // Write data
    } sqadc_apb_req_s;
    typedef struct packed {
        logic        pready;   // Transfer done
        logic [31:0] prdata;   // Read data
        logic        pslverr;  // Unmapped address
    } sqadc_apb_rsp_s;
    typedef struct packed {
        logic [2:0]  chan;     // Input mux select
        logic [11:0] dac;      // Trial code to comparator
        logic        conv;     // Converting
        logic        sample;   // Track phase
    } sqadc_ana_s;
    // ***********************************************
    // Whole module state
    // ***********************************************
    typedef struct packed {
        logic             en;      // Sequencer enable
        logic             fw;      // Firmware-driven selection
        logic             fw_pend; // Firmware start pending
        logic [2:0]       fw_chan; // Firmware channel
        logic [7:0]       chen;    // Scan channel enables
        logic [2:0]       intr;    // Sticky events
        logic [2:0]       mask;    // Event enables
        logic [11:0]      lim_lo;  // Low limit
        logic [11:0]      lim_hi;  // High limit
        logic [7:0][7:0]  samp;    // Sample time per channel
        logic [7:0][11:0] res;     // Result per channel
        logic [7:0]       rvalid;  // Fresh result flags
        sqadc_state_e     state;   // Sequencer state
        logic [2:0]       chan;    // Active channel
        logic [7:0]       cnt;     // Phase counter
        logic [11:0]      approx;  // Approximation register
        sqadc_apb_rsp_s   rsp;     // Bus answer
        logic             irq;     // Interrupt line
    } sqadc_regs_s;
endpackage : sqadc_pkg

// ### hw/sqadc_top.sv
// SAR converter channel sequencer with APB registers
// Function
// - Converter clock within limit, 18-cycle conversions
// - Every conversion yields a 12-bit result
// - One of eight channels chosen per conversion
// - Scan steps enabled channels with no idle
// - State machine or firmware selects the channel
// - Separate result holding register per channel
// - Per-channel sample duration applied before converting
// - Sample window length is software programmable
// - Out-of-range result raises interrupt at once
// - Sequencer inactive during deep sleep
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "sqadc_consts.svh"

module sqadc_top
    import sqadc_pkg::*;
#(
    parameter int CONV_CYCLES = `SQADC_CONV_CYCLES, // Clocks per conversion
    parameter int NUM_CHAN    = 8                   // Mux inputs
) (
    input  wire logic           clock_i,      // 10 MHz clock
    input  wire logic           rst_b_i,      // Synchronous reset, low
    input  wire sqadc_apb_req_s apb_i,        // APB request
    output sqadc_apb_rsp_s      apb_o,        // APB answer
    input  wire logic           deep_sleep_i, // Device in deep sleep
    input  wire logic           cmp_i,        // Input above trial code
    output sqadc_ana_s          ana_o,        // Mux, track and DAC
    output logic                busy_o,       // Sample or conversion
    output logic                irq_o         // Level interrupt
);

    // ***********************************************
    // Timing checks
    // ***********************************************
    // Cycles one conversion spans at the top converter rate
    localparam int CYC_PER_SAMPLE = `SQADC_CONV_MAX_HZ / `SQADC_RATE_SPS;
    // Last count of the conversion phase
    localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
    // Count where the bit trials end
    localparam logic [7:0] BIT_END = 8'(`SQADC_BIT_CYCLES);

    // Clock is used directly as converter clock, so it must stay legal
    if (`SQADC_CLK_HZ > `SQADC_CONV_MAX_HZ) begin : g_bad_clk
        $error("Converter clock too fast");
    end
    // Fewer cycles would exceed the sample rate at the top converter clock
    if (CONV_CYCLES < CYC_PER_SAMPLE) begin : g_bad_conv
        $error("Conversion too short");
    end

    // ***********************************************
    // State
    // ***********************************************
    // All state in one record
    sqadc_regs_s r;        // Registered state
    sqadc_regs_s next_r;   // Next state

    // Bus helpers
    logic        acc;      // Access phase this cycle
    logic        done;     // Transfer completes at this edge

    // Sequencer helpers
    logic [2:0]  ev_set;   // Events raised this cycle
    logic [2:0]  nxt_ch;   // Next enabled channel in scan
    logic [3:0]  bit_ix;   // Bit under trial
    logic        go_auto;  // Scan may run
    logic        oor;      // Result outside limits

    // ***********************************************
    // Functions
    // ***********************************************
    // Next enabled channel after cur, wrapping round
    function automatic logic [2:0] next_chan(
        input logic [7:0] en,
        input logic [2:0] cur
    );
        logic [2:0] c;
        logic       hit;
        c   = cur;
        hit = 1'b0;
        // Search upward, wrapping
        for (int i = 1; i <= NUM_CHAN; i++) begin
            if (!hit && en[3'(cur + 3'(i))]) begin
                c   = 3'(cur + 3'(i));
                hit = 1'b1;
            end
        end

        // No hit keeps cur
        return c;
    endfunction : next_chan

    // True for an address that holds a register
    function automatic logic mapped(input logic [7:0] a);
        logic ok;
        // Aligned words only
        ok = (a[1:0] == 2'b00) && ((a <= `SQADC_LIMHI_OFS)
             || (a[7:5] == `SQADC_SAMP_BASE) || (a[7:5] == `SQADC_RES_BASE));
        return ok;
    endfunction : mapped

    // Read value of one register
    function automatic logic [31:0] rd_val(
        input sqadc_regs_s s,
        input logic [7:0]  a
    );
        logic [31:0] v;
        // Spare bits read zero
        v = 32'h0000_0000;
        // Windows, then fixed words
        if (a[7:5] == `SQADC_SAMP_BASE) begin
            v[7:0] = s.samp[a[4:2]];
        end else if (a[7:5] == `SQADC_RES_BASE) begin
            v[11:0] = s.res[a[4:2]];
            v[`SQADC_RES_VALID] = s.rvalid[a[4:2]];
        end else begin
            // Fixed register words
            unique case (a)
                `SQADC_CTRL_OFS: begin
                    v[`SQADC_CTRL_EN] = s.en;
                    v[`SQADC_CTRL_FW] = s.fw;
                    v[`SQADC_CTRL_GO] = s.fw_pend;
                    v[6:4]            = s.fw_chan;
                end
                // Scan enables
                `SQADC_CHEN_OFS:  v[7:0]  = s.chen;
                // Live sequencer state for software
                `SQADC_STAT_OFS:  v[5:0]  = {s.state != SQADC_IDLE, s.state, s.chan};
                // Flags and enables
                `SQADC_INTR_OFS:  v[2:0]  = s.intr;
                `SQADC_MASK_OFS:  v[2:0]  = s.mask;
                // Limit pair
                `SQADC_LIMLO_OFS: v[11:0] = s.lim_lo;
                `SQADC_LIMHI_OFS: v[11:0] = s.lim_hi;
                default:          v       = 32'h0000_0000;
            endcase
        end

        return v;
    endfunction : rd_val

    // ***********************************************
    // Next-state logic
    // ***********************************************
    // Bus slave, sequencer and events in one pass
    always_comb begin
        next_r  = r;
        ev_set  = 3'h0;
        // Bus qualifiers
        acc     = apb_i.psel & apb_i.penable;
        // Completes once pready is out
        done    = acc & r.rsp.pready;
        // Scan successor
        nxt_ch  = next_chan(r.chen, r.chan);
        // Wraps past the last trial
        bit_ix  = 4'(4'hB - r.cnt[3:0]);
        // Scan runs only when enabled, automatic and awake
        go_auto = r.en & ~r.fw & (|r.chen) & ~deep_sleep_i;
        // Outside either limit
        oor     = (r.approx < r.lim_lo) || (r.approx > r.lim_hi);

        // One wait state: answer in the cycle after access starts
        next_r.rsp.pready  = acc & ~r.rsp.pready;
        // Answer idles at zero
        next_r.rsp.prdata  = 32'h0000_0000;
        next_r.rsp.pslverr = 1'b0;
        if (acc && !r.rsp.pready) begin
            // Data sampled a cycle early; side effects use it
            if (!apb_i.pwrite) begin
                next_r.rsp.prdata = rd_val(r, apb_i.paddr);
            end
            // Unmapped ends in error
            next_r.rsp.pslverr = ~mapped(apb_i.paddr);
        end

        // Register writes at the completing edge
        if (done && apb_i.pwrite && mapped(apb_i.paddr)) begin
            // Window block first
            if (apb_i.paddr[7:5] == `SQADC_SAMP_BASE) begin
                // Per-channel sample window
                next_r.samp[apb_i.paddr[4:2]] = apb_i.pwdata[7:0];
            end else begin
                unique case (apb_i.paddr)
                    `SQADC_CTRL_OFS: begin
                        // Control fields
                        next_r.en      = apb_i.pwdata[`SQADC_CTRL_EN];
                        next_r.fw      = apb_i.pwdata[`SQADC_CTRL_FW];
                        next_r.fw_chan = apb_i.pwdata[6:4];
                        // Start request only counts in firmware mode
                        if (apb_i.pwdata[`SQADC_CTRL_GO] && apb_i.pwdata[`SQADC_CTRL_FW]) begin
                            next_r.fw_pend = 1'b1;
                        end
                    end
                    // Plain config words
                    `SQADC_CHEN_OFS:  next_r.chen   = apb_i.pwdata[7:0];
                    `SQADC_MASK_OFS:  next_r.mask   = apb_i.pwdata[2:0];
                    `SQADC_LIMLO_OFS: next_r.lim_lo = apb_i.pwdata[11:0];
                    `SQADC_LIMHI_OFS: next_r.lim_hi = apb_i.pwdata[11:0];
                    // Status, flags and results are read-only
                    default: begin
                    end
                endcase
            end
        end

        // Read of a result retires only the flag it reported
        if (done && !apb_i.pwrite && apb_i.paddr[7:5] == `SQADC_RES_BASE
            && apb_i.paddr[1:0] == 2'b00) begin
            // A new result set wins
            next_r.rvalid[apb_i.paddr[4:2]] = r.rvalid[apb_i.paddr[4:2]]
                                              & ~r.rsp.prdata[`SQADC_RES_VALID];
        end

        // ***********************************************
        // Sequencer
        // ***********************************************
        unique case (r.state)
            SQADC_IDLE: begin
                // Counter parked
                next_r.cnt = 8'h00;
                if (!deep_sleep_i && r.en) begin
                    if (go_auto) begin
                        // Scan picks the next enabled input
                        next_r.chan  = nxt_ch;
                        next_r.cnt   = r.samp[nxt_ch];
                        next_r.state = SQADC_SAMPLE;
                    end else if (r.fw && r.fw_pend) begin
                        // Firmware chosen input, one shot
                        next_r.chan    = r.fw_chan;
                        next_r.cnt     = r.samp[r.fw_chan];
                        // Request consumed
                        next_r.fw_pend = 1'b0;
                        next_r.state   = SQADC_SAMPLE;
                    end
                end
            end

            SQADC_SAMPLE: begin
                // Track for window plus one cycle, then hold
                if (r.cnt == 8'h00) begin
                    next_r.state  = SQADC_CONV;
                    // Mid-scale first trial
                    next_r.approx = `SQADC_DAC_MID;
                end else begin
                    // Window counts down
                    next_r.cnt = r.cnt - 8'h01;
                end
            end

            SQADC_CONV: begin
                // Counts up to the end
                next_r.cnt = r.cnt + 8'h01;
                // One bit resolved per clock, MSB first
                if (r.cnt < BIT_END) begin
                    if (!cmp_i) begin
                        next_r.approx[bit_ix] = 1'b0;
                    end
                    if (bit_ix != 4'h0) begin
                        next_r.approx[bit_ix - 4'h1] = 1'b1;
                    end
                end

                // Remaining cycles pad to the full conversion time
                if (r.cnt == CONV_LAST) begin
                    // New value replaces the old one
                    next_r.res[r.chan]    = r.approx;
                    next_r.rvalid[r.chan] = 1'b1;
                    // Each result is an event
                    ev_set[`SQADC_INT_CONV] = 1'b1;
                    // Range check on every result, mid-scan
                    ev_set[`SQADC_INT_RANGE] = oor;
                    if (go_auto) begin
                        // Wrap back to a lower or the same input ends one pass
                        ev_set[`SQADC_INT_SCAN] = (nxt_ch <= r.chan);
                        // Straight into next sample, no gap
                        next_r.chan  = nxt_ch;
                        next_r.cnt   = r.samp[nxt_ch];
                        next_r.state = SQADC_SAMPLE;
                    end else begin
                        // One shot or scan stopped
                        next_r.state = SQADC_IDLE;
                    end
                end
            end

            // Two-bit code 11 never used
            default: next_r.state = SQADC_IDLE;
        endcase

        // No converter clock in deep sleep: abandon any work
        if (deep_sleep_i) begin
            next_r.state = SQADC_IDLE;
            next_r.cnt   = 8'h00;
        end

        // ***********************************************
        // Interrupt flags
        // ***********************************************
        // Read clears reported bits; a new event beats the clear
        next_r.intr = r.intr;
        // Completed flag reads only
        if (done && !apb_i.pwrite && apb_i.paddr == `SQADC_INTR_OFS) begin
            next_r.intr = r.intr & ~r.rsp.prdata[2:0];
        end
        // Set after clear: no loss
        next_r.intr = next_r.intr | ev_set;
        // Level output follows the flags that will be held
        next_r.irq = |(next_r.intr & next_r.mask);
    end

    // ***********************************************
    // State register
    // ***********************************************
    // Reset gives idle sequencer and wide-open limits
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            // Clear all, then defaults
            r        <= '0;
            // Nonzero windows and limit
            r.samp   <= {8{`SQADC_SAMP_RST}};
            r.lim_hi <= `SQADC_LIMHI_RST;
        end else begin
            // Update on every edge
            r <= next_r;
        end
    end

    // ***********************************************
    // Outputs from flops; busy_o is an OR of two state bits
    // ***********************************************
    // Mux select follows the active channel
    assign ana_o.chan   = r.chan;
    // Trial code is the approximation register itself
    assign ana_o.dac    = r.approx;
    // State bits double as track and convert strobes
    assign ana_o.sample = r.state[0];
    assign ana_o.conv   = r.state[1];
    // Busy when either phase bit is set
    assign busy_o       = r.state[0] | r.state[1];

    // Bus answer and interrupt
    assign apb_o        = r.rsp;
    assign irq_o        = r.irq;

endmodule : sqadc_top

// ### tb/sqadc_assertions.sv
// Port-level assertions for the converter sequencer top
`timescale 1ns/1ps
module sqadc_assertions
    import sqadc_pkg::*;
#(
    parameter int CONV_CYCLES = 18, // Clocks per conversion
    parameter int NUM_CHAN    = 8   // Mux inputs
) (
    input wire logic           clock_i,      // Block clock
    input wire logic           rst_b_i,      // Sync reset, low
    input wire sqadc_apb_req_s apb_i,        // Bus request
    input wire sqadc_apb_rsp_s apb_o,        // Bus answer
    input wire logic           deep_sleep_i, // Sleep request
    input wire logic           cmp_i,        // Comparator
    input wire sqadc_ana_s     ana_o,        // Analog controls
    input wire logic           busy_o,       // Activity
    input wire logic           irq_o         // Interrupt
);
    // ***********************************************
    // One clock domain, so shared clocking and disable
    // ***********************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    conv_len_a: assert property (disable iff (!rst_b_i || deep_sleep_i)
        $rose(ana_o.conv) |-> ana_o.conv[*8] ##1 ana_o.conv[*8] ##1 ana_o.conv[*2] ##1 !ana_o.conv)
        else $error("conversion not eighteen cycles");
    first_trial_a: assert property ($rose(ana_o.conv) |-> ana_o.dac == 12'h800)
        else $error("first trial code wrong");
    bit_keep_a: assert property ($rose(ana_o.conv) ##1 ana_o.conv |->
        ana_o.dac[11] == $past(cmp_i) && ana_o.dac[10]) else $error("top bit not kept");
    no_overlap_a: assert property (!(ana_o.sample && ana_o.conv))
        else $error("track and convert together");
    busy_map_a: assert property (busy_o == (ana_o.sample || ana_o.conv))
        else $error("busy not tied to phases");
    samp_first_a: assert property ($rose(ana_o.conv) |->
        $past(ana_o.sample) && $stable(ana_o.chan)) else $error("convert without track");
    sleep_idle_a: assert property (deep_sleep_i[*3] |-> !busy_o)
        else $error("active in deep sleep");
    irq_hold_a: assert property ($fell(irq_o) |-> $past(apb_i.psel) ||
        $past(apb_i.psel, 2) || $past(apb_i.psel, 3)) else $error("irq dropped alone");
    ready_pulse_a: assert property (apb_o.pready |->
        $past(apb_i.psel && apb_i.penable) ##1 !apb_o.pready) else $error("bad pready");
    rdata_idle_a: assert property (!apb_o.pready |-> apb_o.prdata == 32'h0 && !apb_o.pslverr)
        else $error("read bus not idle");
endmodule : sqadc_assertions

bind sqadc_top sqadc_assertions #(.CONV_CYCLES(CONV_CYCLES), .NUM_CHAN(NUM_CHAN)) u_chk (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .apb_i(apb_i), .apb_o(apb_o),
    .deep_sleep_i(deep_sleep_i), .cmp_i(cmp_i), .ana_o(ana_o), .busy_o(busy_o), .irq_o(irq_o));

// ### tb/sqadc_ana_model.sv
// Behavioural input pins and comparator facing the sequencer
`timescale 1ns/1ps
module sqadc_ana_model
    import sqadc_pkg::*;
(
    input  wire logic             clock_i, // Bench clock
    input  wire sqadc_ana_s       ana_i,   // Mux, track and trial code
    input  wire logic [7:0][11:0] vin_i,   // Held level per channel
    output logic                  cmp_o    // Comparator decision
);
    logic junk = 1'b0; // Toggles so a stale decision never looks valid
    // Noise pattern outside conversions
    always @(posedge clock_i) junk <= ~junk;
    // Decision only meaningful while converting
    assign cmp_o = ana_i.conv ? (vin_i[ana_i.chan] >= ana_i.dac) : junk;
endmodule : sqadc_ana_model

// ### tb/tb_sar_adc_channel_sequencer.sv
// Self-checking bench: APB master, analog model, firmware, scan and sleep tests
`timescale 1ns/1ps
`include "sqadc_consts.svh"
module tb_sar_adc_channel_sequencer import sqadc_pkg::*;;
    logic             clock_i, rst_b_i, deep_sleep_i, cmp_i, busy_o, irq_o, err, prev_conv;
    sqadc_apb_req_s   req;          // Bus request
    sqadc_apb_rsp_s   rsp;          // Bus answer
    sqadc_ana_s       ana;          // Analog controls
    logic [7:0][11:0] vin, exp_res; // Levels and last stored results
    logic [31:0]      rd;           // Last read word
    logic [2:0]       chq[$];       // Channel of each conversion start
    int               slq[$];       // Track length before each start
    int n_fail = 0, n_checks = 0, cyc = 0, slen = 0, idle_cnt = 0, scanning = 0;
    sqadc_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .apb_i(req), .apb_o(rsp),
        .deep_sleep_i(deep_sleep_i), .cmp_i(cmp_i), .ana_o(ana), .busy_o(busy_o), .irq_o(irq_o));
    sqadc_ana_model u_ana (.clock_i(clock_i), .ana_i(ana), .vin_i(vin), .cmp_o(cmp_i));
    // ***********************************************
    // Clock, monitor and hang guard
    // ***********************************************
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (ana.sample) slen <= slen + 1;
        if (ana.conv && !prev_conv) begin
            chq.push_back(ana.chan);
            slq.push_back(slen);
            slen <= 0;
        end
        prev_conv <= ana.conv;
        if (scanning != 0 && !busy_o) idle_cnt <= idle_cnt + 1;
        if (cyc > 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ***********************************************
    // Shared tasks and expectations
    // ***********************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clock_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clock_i);
            k++;
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        check(k, 32'h2, "pready late");
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(rd & m, x, "read");
    endtask : rdc
    task automatic wait_busy(input logic lvl);
        int k = 0;
        while (busy_o !== lvl && k < 6000) begin
            @(posedge clock_i);
            k++;
        end
    endtask : wait_busy
    function automatic logic [2:0] nxt(input logic [2:0] c, input logic [7:0] en);
        logic [2:0] n = c;
        for (int i = 0; i < 8; i++) begin
            n = n + 3'd1;
            if (en[n]) return n;
        end
        return c;
    endfunction : nxt
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ***********************************************
    // Main sequence
    // ***********************************************
    initial begin
        logic [2:0] ch;
        logic [11:0] v, lo, hi;
        logic [7:0] s, en;
        logic oor;
        void'($urandom(32'h5ab9));
        req = '0;
        rst_b_i = 1'b0;
        deep_sleep_i = 1'b0;
        vin = '0;
        exp_res = '0;
        prev_conv = 1'b0;
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rdc(8'h20, 32'hFF, 32'h03);
        rdc(`SQADC_LIMHI_OFS, 32'hFFF, 32'hFFF);
        apb(1'b0, 8'h1C, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped");
        $display("test reset done");
        wr_mask: apb(1'b1, `SQADC_MASK_OFS, 32'h1);
        // Firmware-chosen conversions with corner limits and track times
        for (int i = 0; i < 6; i++) begin
            ch = 3'($urandom_range(7));
            v = (i == 0) ? 12'hFFF : 12'($urandom_range(4095));
            lo = (i == 1) ? v : 12'($urandom_range(1024));
            hi = (i == 0) ? 12'hFFE : 12'(3072 + $urandom_range(1023));
            s = (i == 2) ? 8'h00 : (i == 3) ? 8'hFF : 8'($urandom_range(15));
            oor = (v < lo) || (v > hi);
            vin[ch] <= v;
            apb(1'b1, 8'h20 + {3'h0, ch, 2'h0}, {24'h0, s});
            apb(1'b1, `SQADC_LIMLO_OFS, {20'h0, lo});
            apb(1'b1, `SQADC_LIMHI_OFS, {20'h0, hi});
            apb(1'b1, `SQADC_CTRL_OFS, {25'h0, ch, 4'h7});
            wait_busy(1'b1);
            wait_busy(1'b0);
            repeat (2) @(posedge clock_i);
            check(slq[$], 32'(s) + 1, "track length");
            check({31'h0, irq_o}, {31'h0, oor}, "irq level");
            rdc(`SQADC_INTR_OFS, 32'h5, {29'h0, 2'b10, oor});
            rdc(`SQADC_INTR_OFS, 32'h5, 32'h0);
            check({31'h0, irq_o}, 32'h0, "irq clear");
            rdc(8'h40 + {3'h0, ch, 2'h0}, 32'h8000_0FFF, {20'h80000, v});
            rdc(8'h40 + {3'h0, ch, 2'h0}, 32'h8000_0FFF, {20'h0, v});
            exp_res[ch] = v;
        end
        $display("test firmware done");
        // Sleep in mid-conversion aborts and stores nothing
        vin[5] <= ~exp_res[5];
        apb(1'b1, `SQADC_CTRL_OFS, 32'h57);
        while (ana.conv !== 1'b1) @(posedge clock_i);
        repeat (5) @(posedge clock_i);
        deep_sleep_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        check({31'h0, busy_o}, 32'h0, "sleep busy");
        deep_sleep_i <= 1'b0;
        rdc(8'h54, 32'h8000_0FFF, {20'h0, exp_res[5]});
        rdc(`SQADC_STAT_OFS, 32'h3F, 32'h05);
        wait_busy(1'b0);
        $display("test sleep done");
        // Autonomous scan over random enables
        en = 8'($urandom_range(254) + 1);
        for (int c = 0; c < 8; c++) vin[c] <= 12'($urandom_range(4095));
        apb(1'b1, `SQADC_CHEN_OFS, {24'h0, en});
        chq.delete();
        apb(1'b1, `SQADC_CTRL_OFS, 32'h1);
        wait_busy(1'b1);
        scanning = 1;
        while (chq.size() < 10 && cyc < 50000) @(posedge clock_i);
        scanning = 0;
        apb(1'b1, `SQADC_CTRL_OFS, 32'h0);
        wait_busy(1'b0);
        check(idle_cnt, 32'h0, "scan gap");
        for (int j = 1; j < 10; j++) check(chq[j], nxt(chq[j-1], en), "scan order");
        for (int c = 0; c < 8; c++) if (en[c]) rdc(8'h40 + 8'(c * 4), 32'hFFF, vin[c]);
        rdc(`SQADC_INTR_OFS, 32'h2, 32'h2);
        $display("test scan done");
        tally_and_finish();
    end
endmodule : tb_sar_adc_channel_sequencer
